// >>> pkg/ecc_array_pkg.sv
package ecc_array_pkg;

  // Array geometry
  localparam int ADDR_W    = 8;
  localparam int GROUPS    = 64;
  localparam int GRP_W     = 6;
  localparam int DATA_W    = 32;
  localparam int CHK_W     = 16;
  localparam int X4_CHK_N  = 6;
  localparam int X1_CHK_N  = 4;
  localparam int BYTE_W    = 8;
  localparam int COL_MIN_W = 4;
  localparam int INJ_W     = 6;
  localparam int POS_LAST  = 38;

  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RST   = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST  = 32'h00000000;
  localparam logic [CHK_W-1:0]  CHK_RST   = 16'h0000;

  // Page length select: 16, 32, 64 or 128 bytes
  typedef enum logic [1:0] {PAGE_16, PAGE_32, PAGE_64, PAGE_128} page_len_e;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE_BEGIN,
    CMD_WRITE_DATA,
    CMD_FILL,
    CMD_INJECT
  } cmd_e;

  typedef struct packed {
    cmd_e              cmd;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } req_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              err;
  } fix_s;

  // Check bits of the n low data bits over non power-of-two positions
  function automatic logic [5:0] ham_calc(input logic [DATA_W-1:0] d, input int n);
    logic [5:0] c;
    int         k;
    c = 6'h00;
    k = 0;
    for (int p = 3; p <= POS_LAST; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (k < n && d[k])
          c = c ^ p[5:0];
        k++;
      end
    end
    return c;
  endfunction : ham_calc

  // Flips the data bit whose position matches the syndrome
  function automatic logic [DATA_W-1:0] ham_flip(input logic [DATA_W-1:0] d,
                                                 input logic [5:0] syn, input int n);
    logic [DATA_W-1:0] r;
    int                k;
    r = d;
    k = 0;
    for (int p = 3; p <= POS_LAST; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (k < n && p[5:0] == syn)
          r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction : ham_flip

  function automatic logic [CHK_W-1:0] gen_check(input logic [DATA_W-1:0] d,
                                                 input logic per_byte);
    logic [CHK_W-1:0] c;
    logic [5:0]       s;
    c = CHK_RST;
    if (per_byte)
    begin
      for (int b = 0; b < 4; b++)
      begin
        s = ham_calc({24'h000000, d[8*b +: BYTE_W]}, BYTE_W);
        c[4*b +: X1_CHK_N] = s[X1_CHK_N-1:0];
      end
    end
    else
      c[X4_CHK_N-1:0] = ham_calc(d, DATA_W);
    return c;
  endfunction : gen_check

  function automatic fix_s correct_group(input logic [DATA_W-1:0] d,
                                         input logic [CHK_W-1:0] c, input logic per_byte);
    fix_s       f;
    logic [5:0] syn;
    logic [DATA_W-1:0] bd;
    f.data = d;
    f.err  = 1'b0;
    if (per_byte)
    begin
      for (int b = 0; b < 4; b++)
      begin
        bd  = {24'h000000, d[8*b +: BYTE_W]};
        syn = ham_calc(bd, BYTE_W) ^ {2'b00, c[4*b +: X1_CHK_N]};
        bd  = ham_flip(bd, syn, BYTE_W);
        f.data[8*b +: BYTE_W] = bd[BYTE_W-1:0];
        if (syn != 6'h00)
          f.err = 1'b1;
      end
    end
    else
    begin
      syn    = ham_calc(d, DATA_W) ^ c[X4_CHK_N-1:0];
      f.data = ham_flip(d, syn, DATA_W);
      f.err  = (syn != 6'h00);
    end
    return f;
  endfunction : correct_group

endpackage : ecc_array_pkg

// >>> rtl/ecc_array.sv
`timescale 1ns/10ps
// Behaviour
// - Four-byte mode: six check bits per group
// - Four-byte mode corrects any single-bit group error
// - Four-byte byte write reprograms whole group
// - Group chosen by address without two LSBs
// - Per-byte mode: four check bits per byte
// - Per-byte mode corrects single-bit byte error
// - Column bits low by page length, page high
// - No write cycle counting or limiting
// - Test fill writes whole array in one cycle
// - Write pointer wraps inside the same page
module ecc_array
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          srst_i,
  // Configuration
  input  wire logic                          per_byte_mode_i,
  input  wire ecc_array_pkg::page_len_e      page_len_i,
  // Requests from the command front end
  input  wire logic                          req_valid_i,
  input  wire ecc_array_pkg::req_s           req_i,
  // Answers
  output logic                               busy_o,
  output logic                               rvalid_o,
  output logic [ecc_array_pkg::BYTE_W-1:0]   rdata_o,
  output logic                               corrected_o,
  output logic                               done_o,
  output logic [ecc_array_pkg::ADDR_W-1:0]   ptr_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} state_e;

  state_e                              state;
  logic [ecc_array_pkg::DATA_W-1:0]    mem_data [ecc_array_pkg::GROUPS];
  logic [ecc_array_pkg::CHK_W-1:0]     mem_chk  [ecc_array_pkg::GROUPS];
  logic [ecc_array_pkg::DATA_W-1:0]    grp_data;
  logic [ecc_array_pkg::CHK_W-1:0]     grp_chk;
  logic [ecc_array_pkg::ADDR_W-1:0]    op_addr;
  logic [ecc_array_pkg::BYTE_W-1:0]    op_byte;
  logic [ecc_array_pkg::ADDR_W-1:0]    ptr;
  logic [ecc_array_pkg::ADDR_W-1:0]    col_mask;
  logic [ecc_array_pkg::ADDR_W-1:0]    next_ptr;
  logic [ecc_array_pkg::GRP_W-1:0]     op_grp;
  logic [ecc_array_pkg::GRP_W-1:0]     req_grp;
  logic [1:0]                          op_lane;
  ecc_array_pkg::fix_s                 fix;
  logic [ecc_array_pkg::DATA_W-1:0]    merged;
  logic [ecc_array_pkg::CHK_W-1:0]     merged_chk;
  logic [ecc_array_pkg::DATA_W-1:0]    fill_data;
  logic [ecc_array_pkg::CHK_W-1:0]     fill_chk;
  logic                                take;
  logic [ecc_array_pkg::INJ_W-1:0]     inj_bit;
  ecc_array_pkg::fix_s                 lane_fix;
  logic                                lane_err;
  logic                                fill_take;

  assign take    = req_valid_i && !busy_o;
  assign fill_take = take && req_i.cmd == ecc_array_pkg::CMD_FILL;
  assign req_grp = req_i.addr[ecc_array_pkg::ADDR_W-1:2];
  assign op_grp  = op_addr[ecc_array_pkg::ADDR_W-1:2];
  assign op_lane = op_addr[1:0];
  assign inj_bit = req_i.data[ecc_array_pkg::INJ_W-1:0];

  // Column part is the low 4..7 bits, page part the rest
  assign col_mask = ecc_array_pkg::ADDR_W'((9'h010 << page_len_i) - 9'h001);
  assign next_ptr = (ptr & ~col_mask) | ((ptr + 8'h01) & col_mask);

  assign fix = ecc_array_pkg::correct_group(grp_data, grp_chk, per_byte_mode_i);

  // Per-byte mode judges only the addressed byte; a faulty neighbour
  // must not flag a clean read
  assign lane_fix = ecc_array_pkg::correct_group(
                      {24'h000000, grp_data[8*op_lane +: ecc_array_pkg::BYTE_W]},
                      {12'h000, grp_chk[4*op_lane +: ecc_array_pkg::X1_CHK_N]},
                      1'b1);
  assign lane_err = per_byte_mode_i ? lane_fix.err : fix.err;

  // Merge new byte into the corrected group, fresh check bits over all of it
  always_comb
  begin
    merged = fix.data;
    merged[8*op_lane +: ecc_array_pkg::BYTE_W] = op_byte;
    merged_chk = ecc_array_pkg::gen_check(merged, per_byte_mode_i);
  end

  assign fill_data = {4{req_i.data}};
  assign fill_chk  = ecc_array_pkg::gen_check(fill_data, per_byte_mode_i);

  // Sequencing of read and write cycles
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state    <= ST_IDLE;
      busy_o   <= 1'b0;
      grp_data <= ecc_array_pkg::DATA_RST;
      grp_chk  <= ecc_array_pkg::CHK_RST;
      op_addr  <= ecc_array_pkg::PTR_RST;
      op_byte  <= ecc_array_pkg::BYTE_RST;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (take && req_i.cmd == ecc_array_pkg::CMD_READ)
          begin
            grp_data <= mem_data[req_grp];
            grp_chk  <= mem_chk[req_grp];
            op_addr  <= req_i.addr;
            busy_o   <= 1'b1;
            state    <= ST_RD;
          end
          else if (take && req_i.cmd == ecc_array_pkg::CMD_WRITE_DATA)
          begin
            grp_data <= mem_data[ptr[ecc_array_pkg::ADDR_W-1:2]];
            grp_chk  <= mem_chk[ptr[ecc_array_pkg::ADDR_W-1:2]];
            op_addr  <= ptr;
            op_byte  <= req_i.data;
            busy_o   <= 1'b1;
            state    <= ST_WR;
          end
        end
        ST_RD:
        begin
          busy_o <= 1'b0;
          state  <= ST_IDLE;
        end
        ST_WR:
        begin
          busy_o <= 1'b0;
          state  <= ST_IDLE;
        end
        default:
        begin
          busy_o <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end

  // Answer pulses last one cycle; the read byte holds until the next read
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rvalid_o    <= 1'b0;
      rdata_o     <= ecc_array_pkg::BYTE_RST;
      corrected_o <= 1'b0;
      done_o      <= 1'b0;
    end
    else
    begin
      rvalid_o    <= 1'b0;
      corrected_o <= 1'b0;
      done_o      <= 1'b0;
      case (state)
        ST_IDLE:
          done_o <= fill_take;
        ST_RD:
        begin
          rdata_o     <= fix.data[8*op_lane +: ecc_array_pkg::BYTE_W];
          rvalid_o    <= 1'b1;
          corrected_o <= lane_err;
        end
        ST_WR:
        begin
          corrected_o <= lane_err;
          done_o      <= 1'b1;
        end
        default:
          done_o <= 1'b0;
      endcase
    end
  end

  // Write pointer for incoming data bytes
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      ptr <= ecc_array_pkg::PTR_RST;
    else if (take && req_i.cmd == ecc_array_pkg::CMD_WRITE_BEGIN)
      ptr <= req_i.addr;
    else if (take && req_i.cmd == ecc_array_pkg::CMD_WRITE_DATA)
      ptr <= next_ptr;
  end

  assign ptr_o = ptr;

  // Array cells; no wear counter, the controller owns endurance budgeting
  // Cells are non-volatile in the real part, so reset leaves them untouched
  always_ff @(posedge clk_sys_i)
  begin
    if (!srst_i)
    begin
      if (state == ST_WR)
      begin
        // Per-byte mode reprograms only the addressed byte and its checks
        if (per_byte_mode_i)
        begin
          mem_data[op_grp][8*op_lane +: ecc_array_pkg::BYTE_W] <= op_byte;
          mem_chk[op_grp][4*op_lane +: ecc_array_pkg::X1_CHK_N] <=
            merged_chk[4*op_lane +: ecc_array_pkg::X1_CHK_N];
        end
        else
        begin
          mem_data[op_grp] <= merged;
          mem_chk[op_grp]  <= merged_chk;
        end
      end
      else if (state == ST_IDLE && take && req_i.cmd == ecc_array_pkg::CMD_FILL)
      begin
        for (int g = 0; g < ecc_array_pkg::GROUPS; g++)
        begin
          mem_data[g] <= fill_data;
          mem_chk[g]  <= fill_chk;
        end
      end
      else if (state == ST_IDLE && take && req_i.cmd == ecc_array_pkg::CMD_INJECT)
      begin
        // Test hook: flip one stored cell to exercise correction
        if (inj_bit < 6'h20)
          mem_data[req_grp][inj_bit[4:0]] <= ~mem_data[req_grp][inj_bit[4:0]];
        else
          mem_chk[req_grp][inj_bit[3:0]] <= ~mem_chk[req_grp][inj_bit[3:0]];
      end
    end
  end

endmodule : ecc_array

// >>> tb/ecc_array_props.sv
`timescale 1ns/10ps
module ecc_array_props
(
  // Clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     srst_i,
  // Requests
  input wire ecc_array_pkg::page_len_e page_len_i,
  input wire logic                     req_valid_i,
  input wire ecc_array_pkg::req_s      req_i,
  // Answers
  input wire logic                     busy_o,
  input wire logic                     rvalid_o,
  input wire logic                     corrected_o,
  input wire logic                     done_o,
  input wire logic [7:0]               ptr_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  logic [2:0] cmd;
  logic       take;
  logic [7:0] mask;
  logic [7:0] wrap_ptr;
  assign cmd      = req_i.cmd;
  assign take     = req_valid_i && !busy_o;
  assign mask     = (8'h10 << page_len_i) - 8'h01;
  assign wrap_ptr = (ptr_o & ~mask) | ((ptr_o + 8'h01) & mask);

  property p_read;
    take && cmd == 3'h0 |-> ##[1:2] rvalid_o;
  endproperty
  a_read: assert property (p_read)
    else $error("read not answered");
  property p_wdone;
    take && cmd == 3'h2 |-> ##[1:2] done_o;
  endproperty
  a_wdone: assert property (p_wdone)
    else $error("write not done");
  property p_fill;
    take && cmd == 3'h3 |-> ##[1:2] done_o;
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill not done");
  property p_begin;
    take && cmd == 3'h1 |=> ptr_o == $past(req_i.addr);
  endproperty
  a_begin: assert property (p_begin)
    else $error("pointer not loaded");
  property p_wrap;
    take && cmd == 3'h2 |=> ptr_o == $past(wrap_ptr);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer left page");
  property p_pulse;
    rvalid_o |=> !rvalid_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("read pulse too long");
  property p_corr;
    corrected_o |-> rvalid_o || done_o;
  endproperty
  a_corr: assert property (p_corr)
    else $error("stray correction flag");
  property p_busy;
    $rose(busy_o) |-> ##[1:2] (rvalid_o || done_o);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy without answer");
endmodule : ecc_array_props

bind ecc_array ecc_array_props props
(
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .page_len_i(page_len_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o), .rvalid_o(rvalid_o),
  .corrected_o(corrected_o), .done_o(done_o), .ptr_o(ptr_o)
);

// >>> tb/front_end_model.sv
`timescale 1ns/10ps
module front_end_model
(
  // Clock and core status
  input  wire logic                clk_sys_i,
  input  wire logic                busy_i,
  // Bench control
  input  wire logic                go_i,
  input  wire ecc_array_pkg::req_s next_i,
  // Request to the core
  output logic                     req_valid_o,
  output ecc_array_pkg::req_s      req_o,
  output logic                     taken_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_o       = '0;
    taken_o     = 1'b0;
  end
  always @(posedge clk_sys_i)
    taken_o <= req_valid_o && !busy_i;
  // Released fields inverted so nothing rides on a stale value
  always @(negedge clk_sys_i)
  begin
    if (go_i)
    begin
      req_valid_o <= 1'b1;
      req_o       <= next_i;
    end
    else if (taken_o)
    begin
      req_valid_o <= 1'b0;
      req_o       <= ecc_array_pkg::req_s'(~req_o);
    end
  end
endmodule : front_end_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                     clk_sys_i = 1'b0;
  logic                     srst_i = 1'b1;
  logic                     mode = 1'b0;
  ecc_array_pkg::page_len_e plen = ecc_array_pkg::PAGE_16;
  logic                     go = 1'b0;
  ecc_array_pkg::req_s      nxt = '0;
  ecc_array_pkg::req_s      req;
  logic                     vld, taken, busy, rvalid, corr, done;
  logic [7:0]               rdata, ptr;
  int                       mismatches = 0;
  int                       checked = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  ecc_array DUT
  (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .per_byte_mode_i(mode), .page_len_i(plen),
    .req_valid_i(vld), .req_i(req), .busy_o(busy), .rvalid_o(rvalid), .rdata_o(rdata),
    .corrected_o(corr), .done_o(done), .ptr_o(ptr)
  );
  front_end_model FE
  (
    .clk_sys_i(clk_sys_i), .busy_i(busy), .go_i(go), .next_i(nxt),
    .req_valid_o(vld), .req_o(req), .taken_o(taken)
  );

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input ecc_array_pkg::cmd_e c, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    nxt = '{cmd: c, addr: a, data: d};
    go = 1'b1;
    @(negedge clk_sys_i) #1;
    go = 1'b0;
    for (int n = 0; n < 20 && taken !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    if (taken !== 1'b1)
    begin
      mismatches++;
      $display("FAIL %0t request not taken", $time);
    end
  endtask : send

  // Answer pulses last one cycle, so poll every cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ec);
    send(ecc_array_pkg::CMD_READ, a, 8'h00);
    for (int n = 0; n < 10 && rvalid !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    chk({rvalid, rdata}, {1'b1, e});
    chk({7'h00, rvalid, corr}, {7'h00, 1'b1, ec});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    send(ecc_array_pkg::CMD_WRITE_BEGIN, a, 8'h00);
    send(ecc_array_pkg::CMD_WRITE_DATA, 8'h00, d);
    for (int n = 0; n < 10 && done !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    chk({8'h00, done}, 9'h001);
  endtask : wr

  task automatic t_group;
    send(ecc_array_pkg::CMD_FILL, 8'h00, 8'hA5);
    chk({8'h00, done}, 9'h001);
    rd(8'hFF, 8'hA5, 1'b0);
    send(ecc_array_pkg::CMD_INJECT, 8'h40, 8'h13);
    rd(8'h42, 8'hA5, 1'b1);
    rd(8'h43, 8'hA5, 1'b1);
    rd(8'h3F, 8'hA5, 1'b0);
    wr(8'h41, 8'h3C);
    rd(8'h42, 8'hA5, 1'b0);
    rd(8'h41, 8'h3C, 1'b0);
    send(ecc_array_pkg::CMD_INJECT, 8'h44, 8'h25);
    rd(8'h47, 8'hA5, 1'b1);
    for (int i = 0; i < 9; i++)
      wr(8'h20, 8'(i));
    rd(8'h20, 8'h08, 1'b0);
  endtask : t_group

  task automatic t_byte;
    @(negedge clk_sys_i);
    mode = 1'b1;
    send(ecc_array_pkg::CMD_FILL, 8'h00, 8'h5A);
    chk({8'h00, done}, 9'h001);
    send(ecc_array_pkg::CMD_INJECT, 8'h80, 8'h07);
    rd(8'h80, 8'h5A, 1'b1);
    rd(8'h81, 8'h5A, 1'b0);
    send(ecc_array_pkg::CMD_INJECT, 8'h84, 8'h24);
    rd(8'h85, 8'h5A, 1'b1);
    wr(8'h86, 8'hC3);
    rd(8'h86, 8'hC3, 1'b0);
    rd(8'h80, 8'h5A, 1'b1);
    @(negedge clk_sys_i);
    mode = 1'b0;
  endtask : t_byte

  task automatic t_wrap;
    logic [7:0] m;
    for (int p = 0; p < 4; p++)
    begin
      @(negedge clk_sys_i);
      plen = ecc_array_pkg::page_len_e'(p);
      m = (8'h10 << p) - 8'h01;
      wr(8'h80 | m, 8'h77);
      chk({1'b0, ptr}, 9'h080);
    end
  endtask : t_wrap

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    srst_i = 1'b0;
    t_group();
    t_byte();
    t_wrap();
    print_verdict();
  end

  initial
  begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule : testbench
